// file: hdl/kwu_pkg.sv
/*
 Package for the keypad wake unit: register offsets, field positions,
 reset values and the carrier types shared by the top and its submodules.
 Assumes a byte-wide register port with 16-bit addresses.
*/
package kwu_pkg;
  localparam int KWU_PINS = 8;
  localparam int KWU_UNITS = 2;
  localparam logic [15:0] KWU0_STATUS_CONTROL_ADDR = 16'h003C;
  localparam logic [15:0] KWU1_STATUS_CONTROL_ADDR = 16'h003D;
  localparam logic [15:0] KWU0_PIN_ENABLE_ADDR = 16'h307C;
  localparam logic [15:0] KWU0_EDGE_SELECT_ADDR = 16'h307D;
  localparam logic [15:0] KWU1_PIN_ENABLE_ADDR = 16'h307E;
  localparam logic [15:0] KWU1_EDGE_SELECT_ADDR = 16'h307F;
  localparam logic [15:0] KWU_IRQ_STATUS_ADDR = 16'h3080;
  localparam logic [15:0] KWU_IRQ_ENABLE_ADDR = 16'h3081;
  localparam logic [15:0] KWU_IRQ_CLEAR_ADDR = 16'h3082;
  localparam int KWU_FLAG_BIT = 3;
  localparam int KWU_ACK_BIT = 2;
  localparam int KWU_IRQ_ENABLE_BIT = 1;
  localparam int KWU_MODE_BIT = 0;
  localparam logic [7:0] KWU_REG_RESET = 8'h00;
  typedef struct packed {
    logic [7:0] pin_enables;
    logic [7:0] polarity_selects;
    logic detect_mode;
    logic irq_enable;
  } kwu_config_type;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } kwu_bus_type;
endpackage

// file: hdl/kwu_detect.sv
/*
 Pin detector for one unit. Input pins must already be synchronised to clk.
 Produces a one-cycle detect pulse per edge, held high with the level in level mode, and the level-held indication.
*/
`timescale 1ns/1ps
module kwu_detect
  import kwu_pkg::*;
#(
  parameter int PINS = KWU_PINS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Configuration and pins
  input wire kwu_config_type cfg,
  input wire logic [PINS-1:0] pins_sync,
  // Results
  output logic detect,
  output logic level_held
);
  logic [PINS-1:0] prev_asserted;
  wire [PINS-1:0] asserted = ~(pins_sync ^ cfg.polarity_selects[PINS-1:0]);
  wire [PINS-1:0] active = asserted & cfg.pin_enables[PINS-1:0];
  wire [PINS-1:0] edge_seen = active & ~prev_asserted;
  assign level_held = cfg.detect_mode && (|active);
  // Any edge, or a held level in level mode, sets the flag
  assign detect = (|edge_seen) || level_held;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prev_asserted <= '1;
    else if (clk_en)
      prev_asserted <= active;
  end

  edge_before_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !cfg.detect_mode && detect |-> $past(~active) != '0)
    else $error("edge reported without a deasserted previous sample");
endmodule

// file: hdl/kwu_stop_catch.sv
/*
 Stop-mode catcher. While stop is asserted the bus clock is assumed gated;
 an enabled pin reaching its asserted level with irq_enable set sets an asynchronous latch.
 The latch is released by acknowledge in the clk domain.
*/
`timescale 1ns/1ps
module kwu_stop_catch
  import kwu_pkg::*;
#(
  parameter int PINS = KWU_PINS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Stop request and pins
  input wire logic stop_mode,
  input wire kwu_config_type cfg,
  input wire logic [PINS-1:0] pins_raw,
  input wire logic release_catch,
  // Result
  output logic caught_async,
  output logic caught_sync
);
  logic sync1;
  wire any_asserted = |(~(pins_raw ^ cfg.polarity_selects[PINS-1:0]) & cfg.pin_enables[PINS-1:0]);
  wire trigger = stop_mode && cfg.irq_enable && any_asserted;

  // Held through stop without a clock; cleared only by acknowledge or reset
  always_ff @(posedge trigger or negedge arst_n or posedge release_catch)
  begin
    if (!arst_n)
      caught_async <= 1'b0;
    else if (release_catch)
      caught_async <= 1'b0;
    else
      caught_async <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= 1'b0;
      caught_sync <= 1'b0;
    end
    else
    begin
      sync1 <= caught_async;
      caught_sync <= sync1;
    end
  end
endmodule

// file: hdl/kwu_top.sv
/*
 Keypad wake unit with two instances and a byte register port.
 Pins are asynchronous and synchronised here; stop_mode and wait_mode come
 from the power controller on clk. Reads return data one cycle later.
*/
`timescale 1ns/1ps
module kwu_top
  import kwu_pkg::*;
#(
  parameter int PINS = KWU_PINS
)
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Keypad input pins per instance
  input wire logic [PINS-1:0] keypad_input_pin0,
  input wire logic [PINS-1:0] keypad_input_pin1,
  // Power mode and outputs
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic debug_halt,
  output logic [KWU_UNITS-1:0] keypad_irq,
  output logic wake,
  output logic irq
);
  kwu_config_type cfg [KWU_UNITS];
  logic [KWU_UNITS-1:0] flag;
  logic [KWU_UNITS-1:0] status;
  logic [KWU_UNITS-1:0] enable;
  logic [PINS-1:0] sync1 [KWU_UNITS];
  logic [PINS-1:0] sync2 [KWU_UNITS];
  logic [KWU_UNITS-1:0] detect;
  logic [KWU_UNITS-1:0] level_held;
  logic [KWU_UNITS-1:0] caught_async;
  logic [KWU_UNITS-1:0] caught_sync;
  logic [KWU_UNITS-1:0] caught_prev;
  logic [KWU_UNITS-1:0] caught_rise;
  logic [KWU_UNITS-1:0] wake_term;
  kwu_bus_type bus;
  logic [KWU_UNITS-1:0] ack;
  logic [KWU_UNITS-1:0] next_flag;
  logic [7:0] next_rdata;
  wire [PINS-1:0] pins_raw [KWU_UNITS];
  assign pins_raw[0] = keypad_input_pin0;
  assign pins_raw[1] = keypad_input_pin1;
  // Register port bundled for the checks below
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Debug halt is ignored on purpose: detection runs as in run mode
  wire unused_debug = debug_halt;
  wire sc_hit0 = (addr == KWU0_STATUS_CONTROL_ADDR);
  wire sc_hit1 = (addr == KWU1_STATUS_CONTROL_ADDR);
  wire pe_hit0 = (addr == KWU0_PIN_ENABLE_ADDR);
  wire es_hit0 = (addr == KWU0_EDGE_SELECT_ADDR);
  wire pe_hit1 = (addr == KWU1_PIN_ENABLE_ADDR);
  wire es_hit1 = (addr == KWU1_EDGE_SELECT_ADDR);
  wire [KWU_UNITS-1:0] sc_hit = {sc_hit1, sc_hit0};
  wire [KWU_UNITS-1:0] pe_hit = {pe_hit1, pe_hit0};
  wire [KWU_UNITS-1:0] es_hit = {es_hit1, es_hit0};
  wire st_hit = (addr == KWU_IRQ_STATUS_ADDR);
  wire en_hit = (addr == KWU_IRQ_ENABLE_ADDR);
  wire clr_hit = (addr == KWU_IRQ_CLEAR_ADDR);
  wire [KWU_UNITS-1:0] clr_bits = (wr && clr_hit) ? wdata[KWU_UNITS-1:0] : '0;
  // Any readable register; the clear register is not included
  wire any_hit = (|sc_hit) || (|pe_hit) || (|es_hit) || st_hit || en_hit;

  function automatic logic [7:0] sc_view(input kwu_config_type c, input logic f);
    sc_view = KWU_REG_RESET;
    sc_view[KWU_FLAG_BIT] = f;
    sc_view[KWU_IRQ_ENABLE_BIT] = c.irq_enable;
    sc_view[KWU_MODE_BIT] = c.detect_mode;
  endfunction

  genvar u;
  generate
    for (u = 0; u < KWU_UNITS; u++)
    begin : g_unit
      assign ack[u] = clk_en && wr && sc_hit[u] && wdata[KWU_ACK_BIT];
      // Set wins over acknowledge; level mode keeps the flag while held
      assign next_flag[u] = detect[u] || caught_rise[u] ? 1'b1 :
        (ack[u] && !level_held[u]) ? 1'b0 : flag[u];
      assign keypad_irq[u] = flag[u] && cfg[u].irq_enable;
      // A stop catch sets the flag once; its level lingers until the sync drains
      assign caught_rise[u] = caught_sync[u] && !caught_prev[u];
      assign wake_term[u] = keypad_irq[u] || (caught_async[u] && cfg[u].irq_enable);

      // Frozen with clk_en so a catch made in stop is seen when the clock returns
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          caught_prev[u] <= 1'b0;
        else if (clk_en)
          caught_prev[u] <= caught_sync[u];
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sync1[u] <= '0;
          sync2[u] <= '0;
        end
        else if (clk_en)
        begin
          sync1[u] <= pins_raw[u];
          sync2[u] <= sync1[u];
        end
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cfg[u] <= '0;
          flag[u] <= 1'b0;
        end
        else if (clk_en)
        begin
          flag[u] <= next_flag[u];
          if (wr && sc_hit[u])
          begin
            cfg[u].irq_enable <= wdata[KWU_IRQ_ENABLE_BIT];
            cfg[u].detect_mode <= wdata[KWU_MODE_BIT];
          end
          if (wr && pe_hit[u])
            cfg[u].pin_enables <= wdata;
          if (wr && es_hit[u])
            cfg[u].polarity_selects <= wdata;
        end
      end

      kwu_detect #(.PINS(PINS)) u_detect (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .cfg(cfg[u]),
        .pins_sync(sync2[u]),
        .detect(detect[u]),
        .level_held(level_held[u])
      );

      kwu_stop_catch #(.PINS(PINS)) u_catch (
        .clk(clk),
        .arst_n(arst_n),
        .stop_mode(stop_mode),
        .cfg(cfg[u]),
        .pins_raw(pins_raw[u]),
        .release_catch(ack[u]),
        .caught_async(caught_async[u]),
        .caught_sync(caught_sync[u])
      );

      flag_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && detect[u] |=> flag[u])
        else $error("detection did not set the flag");
      ack_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
        ack[u] && !detect[u] && !caught_rise[u] && !level_held[u] |=> !flag[u])
        else $error("acknowledge did not clear the flag");
      level_holds_a: assert property (@(posedge clk) disable iff (!arst_n)
        flag[u] && level_held[u] && ack[u] |=> flag[u])
        else $error("flag cleared while level asserted");
      irq_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        keypad_irq[u] == (flag[u] && cfg[u].irq_enable))
        else $error("request not gated by enable");

      // Flag, catch and wake
      flag_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && flag[u] && !ack[u] |=> flag[u])
        else $error("flag dropped without acknowledge");
      flag_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.wr && sc_hit[u] && !bus.wdata[KWU_ACK_BIT] && !flag[u] && !detect[u] &&
        !caught_rise[u] |=> !flag[u])
        else $error("flag set by a register write");
      level_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && level_held[u] |=> flag[u])
        else $error("held level did not set the flag");
      stop_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && caught_rise[u] |=> flag[u] && status[u])
        else $error("stop catch not carried into the flag");
      stop_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
        stop_mode && caught_async[u] && cfg[u].irq_enable |-> wake)
        else $error("no wake from stop");
      catch_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        ack[u] && !stop_mode |=> !caught_async[u] || stop_mode)
        else $error("stop catch not released by acknowledge");

      // Register writes and reads
      pe_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.wr && pe_hit[u] |=> cfg[u].pin_enables == $past(bus.wdata))
        else $error("pin enable write lost");
      es_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.wr && es_hit[u] |=> cfg[u].polarity_selects == $past(bus.wdata))
        else $error("polarity write lost");
      sc_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.wr && sc_hit[u] |=>
        cfg[u].detect_mode == $past(bus.wdata[KWU_MODE_BIT]) &&
        cfg[u].irq_enable == $past(bus.wdata[KWU_IRQ_ENABLE_BIT]))
        else $error("control write lost");
      flag_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.rd && sc_hit[u] |=> rdata[KWU_FLAG_BIT] == $past(flag[u]))
        else $error("flag readback wrong");
      pe_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.rd && pe_hit[u] |=> rdata == $past(cfg[u].pin_enables))
        else $error("unit pin enable readback wrong");
      es_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && bus.rd && es_hit[u] |=> rdata == $past(cfg[u].polarity_selects))
        else $error("polarity readback wrong");

      // Event status
      status_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && (detect[u] || caught_rise[u]) |=> status[u])
        else $error("event status not set");
      status_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && clr_bits[u] && !detect[u] && !caught_rise[u] |=> !status[u])
        else $error("event status not cleared");
    end
  endgenerate

  // Sticky event status, set wins over clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= '0;
      enable <= '0;
    end
    else if (clk_en)
    begin
      status <= (status & ~clr_bits) | detect | caught_rise;
      if (wr && en_hit)
        enable <= wdata[KWU_UNITS-1:0];
    end
  end

  assign irq = |(status & enable);
  // Wake from wait or stop requires the enable bit
  assign wake = (wait_mode || stop_mode) && (|wake_term);

  // Read mux, registers at fixed addresses
  assign next_rdata = sc_hit0 ? sc_view(cfg[0], flag[0]) :
    sc_hit1 ? sc_view(cfg[1], flag[1]) :
    pe_hit0 ? cfg[0].pin_enables :
    es_hit0 ? cfg[0].polarity_selects :
    pe_hit1 ? cfg[1].pin_enables :
    es_hit1 ? cfg[1].polarity_selects :
    st_hit ? {6'h00, status} :
    en_hit ? {6'h00, enable} : 8'h00;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= KWU_REG_RESET;
    else if (clk_en)
      rdata <= rd ? next_rdata : 8'h00;
  end

  wait_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
    wait_mode && (|keypad_irq) |-> wake)
    else $error("no wake from wait");
  wake_needs_en_a: assert property (@(posedge clk) disable iff (!arst_n)
    wake && !cfg[0].irq_enable && !cfg[1].irq_enable |-> 1'b0)
    else $error("wake without enable");
  read_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && rd && pe_hit0 ##1 clk_en |-> rdata == $past(cfg[0].pin_enables))
    else $error("pin enable readback wrong");

  // Clock enable, read port and event registers
  freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
    !clk_en |=> $stable(flag) && $stable(status) && $stable(enable) && $stable(rdata))
    else $error("state moved while clock enable low");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !bus.rd |=> rdata == 8'h00)
    else $error("read data without a read");
  unmapped_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus.rd && !any_hit |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  sc_reserved_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus.rd && (|sc_hit) |=> rdata[7:4] == 4'h0)
    else $error("reserved control bits not zero");

  status_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !(bus.wr && clr_hit) |=> ($past(status) & ~status) == '0)
    else $error("event status dropped without clear");
  enable_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus.wr && en_hit |=> enable == $past(bus.wdata[KWU_UNITS-1:0]))
    else $error("event enable write lost");
  read_enable_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus.rd && en_hit |=> rdata[KWU_UNITS-1:0] == $past(enable))
    else $error("event enable readback wrong");
  read_status_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus.rd && st_hit |=> rdata[KWU_UNITS-1:0] == $past(status))
    else $error("event status readback wrong");
  wake_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wait_mode && !stop_mode |-> !wake)
    else $error("wake outside wait or stop");
endmodule

// file: verif/kwu_pins_model.sv
/*
 Model of the switches on the keypad pins of both instances.
 Assumes the bench calls drive just after a rising clock edge.
*/
`timescale 1ns/1ps
module kwu_pins_model
(
  // Pin levels toward the unit
  output logic [7:0] pins0,
  output logic [7:0] pins1
);
  // Instance 0 idles high (falling), instance 1 idles low (rising)
  initial
  begin
    pins0 = 8'hFF;
    pins1 = 8'h00;
  end
  task automatic drive(input int unit, input logic [7:0] v);
    if (unit == 0)
      pins0 <= v;
    else
      pins1 <= v;
  endtask
endmodule

// file: verif/keypad_wake_interrupt_test.sv
/*
 Self-checking bench for kwu_top: registers, detection, acknowledge,
 wake from wait and stop, event registers. Assumes the pin model above.
*/
`timescale 1ns/1ps
module keypad_wake_interrupt_test;
  import kwu_pkg::*;
  logic clk, arst_n, clk_en, wr, rd, wait_mode, stop_mode, debug_halt, wake, irq;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, p0, p1;
  logic [1:0] keypad_irq;
  int mismatches, check_count;
  kwu_top uut
  (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .keypad_input_pin0(p0),
    .keypad_input_pin1(p1), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .debug_halt(debug_halt), .keypad_irq(keypad_irq), .wake(wake), .irq(irq)
  );
  kwu_pins_model pins(.pins0(p0), .pins1(p1));
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    chk(rdata, exp);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task reset_values;
    logic [15:0] t [7];
    t = '{16'h003C, 16'h003D, 16'h307C, 16'h307D, 16'h307E, 16'h307F, 16'h3083};
    foreach (t[i])
      rd_chk(t[i], 8'h00);
  endtask
  task readback;
    reg_wr(KWU1_PIN_ENABLE_ADDR, 8'hA5);
    reg_wr(KWU1_EDGE_SELECT_ADDR, 8'h5A);
    reg_wr(KWU0_STATUS_CONTROL_ADDR, 8'hF8);
    rd_chk(KWU1_PIN_ENABLE_ADDR, 8'hA5);
    rd_chk(KWU1_EDGE_SELECT_ADDR, 8'h5A);
    rd_chk(KWU0_STATUS_CONTROL_ADDR, 8'h00);
  endtask
  task edge_only;
    debug_halt <= 1;
    reg_wr(KWU0_EDGE_SELECT_ADDR, 8'h00);
    reg_wr(KWU0_PIN_ENABLE_ADDR, 8'h01);
    reg_wr(KWU0_STATUS_CONTROL_ADDR, 8'h02);
    pins.drive(0, 8'hFD);
    tick(6);
    rd_chk(KWU0_STATUS_CONTROL_ADDR, 8'h02);
    pins.drive(0, 8'hFE);
    tick(6);
    rd_chk(KWU0_STATUS_CONTROL_ADDR, 8'h0A);
    chk({6'h00, keypad_irq}, 8'h01);
    reg_wr(KWU0_STATUS_CONTROL_ADDR, 8'h06);
    rd_chk(KWU0_STATUS_CONTROL_ADDR, 8'h02);
    pins.drive(0, 8'hFF);
    debug_halt <= 0;
  endtask
  task level_mode;
    reg_wr(KWU1_EDGE_SELECT_ADDR, 8'h01);
    reg_wr(KWU1_PIN_ENABLE_ADDR, 8'h01);
    reg_wr(KWU1_STATUS_CONTROL_ADDR, 8'h01);
    reg_wr(KWU1_STATUS_CONTROL_ADDR, 8'h05);
    rd_chk(KWU1_STATUS_CONTROL_ADDR, 8'h01);
    pins.drive(1, 8'h01);
    tick(6);
    rd_chk(KWU1_STATUS_CONTROL_ADDR, 8'h09);
    chk({6'h00, keypad_irq}, 8'h00);
    reg_wr(KWU1_STATUS_CONTROL_ADDR, 8'h05);
    rd_chk(KWU1_STATUS_CONTROL_ADDR, 8'h09);
    pins.drive(1, 8'h00);
    tick(4);
    reg_wr(KWU1_STATUS_CONTROL_ADDR, 8'h05);
    rd_chk(KWU1_STATUS_CONTROL_ADDR, 8'h01);
  endtask
  task wakeups;
    wait_mode <= 1;
    tick(2);
    chk({7'h00, wake}, 8'h00);
    pins.drive(0, 8'hFE);
    tick(6);
    chk({7'h00, wake}, 8'h01);
    wait_mode <= 0;
    pins.drive(0, 8'hFF);
    reg_wr(KWU0_STATUS_CONTROL_ADDR, 8'h06);
    stop_mode <= 1;
    clk_en <= 0;
    tick(2);
    chk({7'h00, wake}, 8'h00);
    pins.drive(0, 8'hFE);
    #3;
    chk({7'h00, wake}, 8'h01);
    tick(2);
    pins.drive(0, 8'hFF);
    clk_en <= 1;
    stop_mode <= 0;
    tick(6);
    rd_chk(KWU0_STATUS_CONTROL_ADDR, 8'h0A);
    reg_wr(KWU0_STATUS_CONTROL_ADDR, 8'h06);
    rd_chk(KWU0_STATUS_CONTROL_ADDR, 8'h02);
  endtask
  task events;
    rd_chk(KWU_IRQ_STATUS_ADDR, 8'h03);
    chk({7'h00, irq}, 8'h00);
    reg_wr(KWU_IRQ_ENABLE_ADDR, 8'h01);
    tick(1);
    chk({7'h00, irq}, 8'h01);
    reg_wr(KWU_IRQ_CLEAR_ADDR, 8'h03);
    tick(1);
    chk({7'h00, irq}, 8'h00);
    rd_chk(KWU_IRQ_STATUS_ADDR, 8'h00);
  endtask
  task end_of_test;
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    end_of_test;
  end
  initial
  begin
    arst_n = 0;
    clk_en = 1;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 0;
    rd = 0;
    wait_mode = 0;
    stop_mode = 0;
    debug_halt = 0;
    mismatches = 0;
    check_count = 0;
    tick(6);
    arst_n <= 1;
    reset_values;
    readback;
    edge_only;
    level_mode;
    wakeups;
    events;
    end_of_test;
  end
endmodule
